/* File: rtl/lbo_pkg.sv */
package lbo_pkg;
   // ==========================================================
   // Register offsets, byte addresses of aligned words
   // ==========================================================
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_PASS = 8'h04;
   localparam logic [7:0] OFF_FPAT = 8'h08;
   localparam logic [7:0] OFF_L1LO = 8'h0C;
   localparam logic [7:0] OFF_L1HI = 8'h10;
   localparam logic [7:0] OFF_L2LO = 8'h14;
   localparam logic [7:0] OFF_L2HI = 8'h18;
   localparam logic [7:0] OFF_CMD = 8'h1C;
   localparam logic [7:0] OFF_STAT = 8'h20;
   localparam logic [7:0] OFF_LAST = 8'h24;
   // ==========================================================
   // Field positions
   // ==========================================================
   localparam int CTRL_L1EN = 0;
   localparam int CTRL_L2EN = 1;
   localparam int CTRL_BSEN = 2;
   localparam int CTRL_POL = 4;
   localparam int CMD_REEVAL = 0;
   localparam int CMD_CLR1 = 1;
   localparam int CMD_CLR2 = 2;
   // ==========================================================
   // Reset values
   // ==========================================================
   localparam logic [3:0] PASS_RST = 4'h0;
   localparam logic [3:0] POL_RST = 4'hF;
   localparam logic [15:0] FPAT_RST = 16'h0000;
   localparam logic [31:0] WORD_RST = 32'h0000_0000;
   // ==========================================================
   // Timing
   // ==========================================================
   localparam int CLK_NS = 10;
   localparam int STROBE_MIN_NS = 10000;
   localparam int STROBE_CYC = STROBE_MIN_NS / CLK_NS + 1;
   localparam int SETTLE_NS = 1000;
   localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
   // ==========================================================
   // Types
   // ==========================================================
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SETTLE = 2'b01,
      ST_PULSE = 2'b10
   } lbo_state_t;
   typedef struct packed {
      logic valid;
      logic [31:0] value;
   } lbo_reading_t;
   typedef struct packed {
      logic act;
      logic write;
      logic [7:0] addr;
   } lbo_aphase_t;
endpackage

/* File: rtl/lbo_limit_bin.sv */
// The register addresses and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ps
// Contract
// - With every enabled limit test passing, the pass pattern (0..15) drives the port.
// - Pattern bit weights 1,2,4,8 map to lines 1..4; a set bit makes that line true.
// - A true line is high under active-high polarity and low under active-low.
// - With the binning strobe enabled, line 4 leaves the pattern, so 8..15 act as 0..7.
// - The strobe enable is 1 for on, 0 for off, and reads back.
// - With the strobe on, lines 1..3 settle first, then line 4 pulses for over 10 us unless a new result cuts the pulse short.
// - The strobe pulse direction follows line 4 polarity.
// - Composite fail is the OR of the two limit fail flags.
// - Reading the composite fail leaves both fail flags unchanged.
// - Limit, pass and fail pattern changes act from the next reading, with no re-test meanwhile.
// - A re-evaluate command re-tests the last reading with current limits, no conversion.
// - Tests run low1, high1, low2, high2; disabled ones skip; first failure picks the pattern.
module lbo_limit_bin #(
   parameter int COUNT_W = 11
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire lbo_pkg::lbo_reading_t reading,
   output logic [3:0] port_out,
   output logic composite_fail
);
   // ==========================================================
   // Elaboration check
   // ==========================================================
   if ((2 ** COUNT_W) <= lbo_pkg::STROBE_CYC) begin : g_chk
      $error("COUNT_W too small for strobe count");
   end

   localparam logic [COUNT_W-1:0] STROBE_LD = COUNT_W'(lbo_pkg::STROBE_CYC - 1);
   localparam logic [COUNT_W-1:0] SETTLE_LD = COUNT_W'(lbo_pkg::SETTLE_CYC - 1);

   // Returns {high_fail, low_fail} for one signed limit pair.
   function automatic logic [1:0] lim_test(input logic [31:0] v,
                                           input logic [31:0] lo,
                                           input logic [31:0] hi);
      lim_test = {$signed(v) > $signed(hi), $signed(v) < $signed(lo)};
   endfunction

   // ==========================================================
   // AHB-Lite slave
   // ==========================================================
   lbo_pkg::lbo_aphase_t aph_reg, aph_next;
   logic [31:0] hrdata_reg, hrdata_next;
   logic hreadyout_reg;
   logic hresp_reg;
   logic dph_wr, dph_rd;
   logic [31:0] rd_mux;

   logic l1en_reg, l2en_reg, bsen_reg;
   logic [3:0] pol_reg, pass_reg;
   logic [15:0] fpat_reg;
   logic [31:0] l1lo_reg, l1hi_reg, l2lo_reg, l2hi_reg, last_reg;
   logic fail1_reg, fail2_reg, comp_reg;
   logic [3:0] true_pat_reg, port_reg;
   lbo_pkg::lbo_state_t state_reg;

   assign dph_wr = aph_reg.act && aph_reg.write;
   assign dph_rd = aph_reg.act && !aph_reg.write;

   // Read data is picked in the address phase, so every access has zero wait states.
   always_comb begin
      unique case (haddr[7:0])
         lbo_pkg::OFF_CTRL: rd_mux = {24'h00_0000, pol_reg, 1'b0, bsen_reg,
                                      l2en_reg, l1en_reg};
         lbo_pkg::OFF_PASS: rd_mux = {28'h000_0000, pass_reg};
         lbo_pkg::OFF_FPAT: rd_mux = {16'h0000, fpat_reg};
         lbo_pkg::OFF_L1LO: rd_mux = l1lo_reg;
         lbo_pkg::OFF_L1HI: rd_mux = l1hi_reg;
         lbo_pkg::OFF_L2LO: rd_mux = l2lo_reg;
         lbo_pkg::OFF_L2HI: rd_mux = l2hi_reg;
         lbo_pkg::OFF_STAT: rd_mux = {24'h00_0000, port_reg, state_reg == lbo_pkg::ST_PULSE,
                                      comp_reg, fail2_reg, fail1_reg};
         lbo_pkg::OFF_LAST: rd_mux = last_reg;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // Address phase capture; unmapped addresses read zero and ignore writes.
   always_comb begin
      aph_next = aph_reg;
      hrdata_next = hrdata_reg;
      if (hready) begin
         aph_next.act = hsel && htrans[1];
         aph_next.write = hwrite;
         aph_next.addr = {haddr[7:2], 2'b00};
         if (hsel && htrans[1] && !hwrite) begin
            hrdata_next = rd_mux;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         aph_reg <= '0;
         hrdata_reg <= 32'h0000_0000;
         hreadyout_reg <= 1'b1;
         hresp_reg <= 1'b0;
      end else begin
         aph_reg <= aph_next;
         hrdata_reg <= hrdata_next;
         hreadyout_reg <= 1'b1;
         hresp_reg <= 1'b0;
      end
   end

   assign hreadyout = hreadyout_reg;
   assign hresp = hresp_reg;
   assign hrdata = hrdata_reg;

   // ==========================================================
   // Configuration registers
   // ==========================================================
   logic wr_ctrl, wr_cmd, reeval, clr1, clr2;
   logic l1en_next, l2en_next, bsen_next;
   logic [3:0] pol_next, pass_next;
   logic [15:0] fpat_next;
   logic [31:0] l1lo_next, l1hi_next, l2lo_next, l2hi_next;

   assign wr_ctrl = dph_wr && aph_reg.addr == lbo_pkg::OFF_CTRL;
   assign wr_cmd = dph_wr && aph_reg.addr == lbo_pkg::OFF_CMD;
   assign reeval = wr_cmd && hwdata[lbo_pkg::CMD_REEVAL];
   assign clr1 = wr_cmd && hwdata[lbo_pkg::CMD_CLR1];
   assign clr2 = wr_cmd && hwdata[lbo_pkg::CMD_CLR2];

   // Writes land in the data phase; new limits and patterns wait for the next evaluation.
   always_comb begin
      l1en_next = l1en_reg;
      l2en_next = l2en_reg;
      bsen_next = bsen_reg;
      pol_next = pol_reg;
      pass_next = pass_reg;
      fpat_next = fpat_reg;
      l1lo_next = l1lo_reg;
      l1hi_next = l1hi_reg;
      l2lo_next = l2lo_reg;
      l2hi_next = l2hi_reg;
      if (wr_ctrl) begin
         l1en_next = hwdata[lbo_pkg::CTRL_L1EN];
         l2en_next = hwdata[lbo_pkg::CTRL_L2EN];
         bsen_next = hwdata[lbo_pkg::CTRL_BSEN];
         pol_next = hwdata[lbo_pkg::CTRL_POL +: 4];
      end
      if (dph_wr) begin
         unique case (aph_reg.addr)
            lbo_pkg::OFF_PASS: pass_next = hwdata[3:0];
            lbo_pkg::OFF_FPAT: fpat_next = hwdata[15:0];
            lbo_pkg::OFF_L1LO: l1lo_next = hwdata;
            lbo_pkg::OFF_L1HI: l1hi_next = hwdata;
            lbo_pkg::OFF_L2LO: l2lo_next = hwdata;
            lbo_pkg::OFF_L2HI: l2hi_next = hwdata;
            default: ;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         l1en_reg <= 1'b0;
         l2en_reg <= 1'b0;
         bsen_reg <= 1'b0;
         pol_reg <= lbo_pkg::POL_RST;
         pass_reg <= lbo_pkg::PASS_RST;
         fpat_reg <= lbo_pkg::FPAT_RST;
         l1lo_reg <= lbo_pkg::WORD_RST;
         l1hi_reg <= lbo_pkg::WORD_RST;
         l2lo_reg <= lbo_pkg::WORD_RST;
         l2hi_reg <= lbo_pkg::WORD_RST;
      end else begin
         l1en_reg <= l1en_next;
         l2en_reg <= l2en_next;
         bsen_reg <= bsen_next;
         pol_reg <= pol_next;
         pass_reg <= pass_next;
         fpat_reg <= fpat_next;
         l1lo_reg <= l1lo_next;
         l1hi_reg <= l1hi_next;
         l2lo_reg <= l2lo_next;
         l2hi_reg <= l2hi_next;
      end
   end

   // ==========================================================
   // Limit evaluation, pattern and strobe
   // ==========================================================
   logic eval_go;
   logic [31:0] val, last_next;
   logic [1:0] t1, t2;
   logic [3:0] sel_pat, true_pat_next, port_next, fp0;
   logic fail1_next, fail2_next, comp_next, in_pulse, in_settle;
   lbo_pkg::lbo_state_t state_next;
   logic [COUNT_W-1:0] cnt_reg, cnt_next;

   // A conversion or a re-evaluate both test; only a conversion replaces the reading.
   assign eval_go = reading.valid || reeval;
   assign val = reading.valid ? reading.value : last_reg;
   assign t1 = l1en_reg ? lim_test(val, l1lo_reg, l1hi_reg) : 2'b00;
   assign t2 = l2en_reg ? lim_test(val, l2lo_reg, l2hi_reg) : 2'b00;
   assign fp0 = fpat_reg[3:0];
   assign in_pulse = state_reg == lbo_pkg::ST_PULSE;
   assign in_settle = state_reg == lbo_pkg::ST_SETTLE;

   // Fixed priority, so the first failing test alone chooses the pattern.
   always_comb begin
      if (t1[0]) begin
         sel_pat = fpat_reg[3:0];
      end else if (t1[1]) begin
         sel_pat = fpat_reg[7:4];
      end else if (t2[0]) begin
         sel_pat = fpat_reg[11:8];
      end else if (t2[1]) begin
         sel_pat = fpat_reg[15:12];
      end else begin
         sel_pat = pass_reg;
      end
   end

   // Set wins over clear; disabling a limit drops its flag, a read never does.
   always_comb begin
      last_next = reading.valid ? reading.value : last_reg;
      fail1_next = (fail1_reg && !clr1 && l1en_next) || (eval_go && t1 != 2'b00);
      fail2_next = (fail2_reg && !clr2 && l2en_next) || (eval_go && t2 != 2'b00);
      comp_next = fail1_next || fail2_next;
      true_pat_next = eval_go ? sel_pat : true_pat_reg;
      true_pat_next[3] = true_pat_next[3] && !bsen_next;
      state_next = state_reg;
      cnt_next = cnt_reg;
      if (!bsen_next) begin
         state_next = lbo_pkg::ST_IDLE;
      end else if (eval_go) begin
         // A new result restarts settling so the binner never sees a stale strobe.
         state_next = lbo_pkg::ST_SETTLE;
         cnt_next = SETTLE_LD;
      end else begin
         unique case (state_reg)
            lbo_pkg::ST_IDLE: ;
            lbo_pkg::ST_SETTLE: begin
               cnt_next = cnt_reg - 1'b1;
               if (cnt_reg == '0) begin
                  state_next = lbo_pkg::ST_PULSE;
                  cnt_next = STROBE_LD;
               end
            end
            lbo_pkg::ST_PULSE: begin
               cnt_next = cnt_reg - 1'b1;
               if (cnt_reg == '0) begin
                  state_next = lbo_pkg::ST_IDLE;
               end
            end
            default: state_next = lbo_pkg::ST_IDLE;
         endcase
      end
      port_next = true_pat_next ^ ~pol_next;
      if (bsen_next) begin
         port_next[3] = (state_next == lbo_pkg::ST_PULSE) ? pol_next[3] : !pol_next[3];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         last_reg <= lbo_pkg::WORD_RST;
         fail1_reg <= 1'b0;
         fail2_reg <= 1'b0;
         comp_reg <= 1'b0;
         true_pat_reg <= lbo_pkg::PASS_RST;
         port_reg <= ~lbo_pkg::POL_RST;
         state_reg <= lbo_pkg::ST_IDLE;
         cnt_reg <= '0;
      end else begin
         last_reg <= last_next;
         fail1_reg <= fail1_next;
         fail2_reg <= fail2_next;
         comp_reg <= comp_next;
         true_pat_reg <= true_pat_next;
         port_reg <= port_next;
         state_reg <= state_next;
         cnt_reg <= cnt_next;
      end
   end

   assign port_out = port_reg;
   assign composite_fail = comp_reg;

   // ==========================================================
   // Assertions
   // ==========================================================
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   logic [COUNT_W-1:0] plen_reg;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         plen_reg <= '0;
      end else begin
         plen_reg <= in_pulse ? plen_reg + 1'b1 : '0;
      end
   end

   pass_pattern_a: assert property (eval_go && t1 == 2'b00 && t2 == 2'b00 && !bsen_next
      |=> true_pat_reg == $past(pass_reg)) else $error("pass pattern not applied");
   polarity_map_a: assert property ({1'b0, port_reg[2:0]} == ((true_pat_reg ^ ~pol_reg)
      & 4'h7)) else $error("line level does not follow polarity");
   strobe_mask_a: assert property (bsen_reg |-> !true_pat_reg[3])
      else $error("line 4 kept in pattern");
   strobe_settle_a: assert property ($rose(in_pulse) |-> $past(in_settle)
      && $stable(port_reg[2:0])) else $error("strobe before settle");
   strobe_width_a: assert property ($fell(in_pulse) && state_reg == lbo_pkg::ST_IDLE
      && bsen_reg |-> $past(plen_reg) == STROBE_LD) else $error("strobe width wrong");
   strobe_level_a: assert property (bsen_reg |-> port_reg[3] == (in_pulse ? pol_reg[3]
      : !pol_reg[3])) else $error("strobe polarity wrong");
   composite_or_a: assert property (comp_reg == (fail1_reg || fail2_reg))
      else $error("composite fail wrong");
   read_keep_a: assert property (dph_rd && !eval_go && !wr_cmd |=> $stable(fail1_reg)
      && $stable(fail2_reg)) else $error("read changed fail flags");
   config_hold_a: assert property (!eval_go && !wr_ctrl |=> $stable(true_pat_reg))
      else $error("pattern changed without evaluation");
   reeval_last_a: assert property (reeval && !reading.valid |=> $stable(last_reg)
      && comp_reg == ($past(t1) != 2'b00 || $past(t2) != 2'b00
      || ($past(fail1_reg) && !$past(clr1)) || ($past(fail2_reg) && !$past(clr2))))
      else $error("re-evaluate misbehaved");
   first_fail_a: assert property (eval_go && t1[0] && !bsen_next
      |=> true_pat_reg == $past(fp0)) else $error("first failure not chosen");

   strobe_done_c: cover property ($fell(in_pulse) && state_reg == lbo_pkg::ST_IDLE);
   reeval_c: cover property (reeval && t2 != 2'b00);
   status_read_c: cover property (dph_rd && aph_reg.addr == lbo_pkg::OFF_STAT && comp_reg);
   restart_c: cover property (in_pulse && eval_go);
endmodule

/* File: verif/lbo_bin_model.sv */
`timescale 1ns/1ps
// ==========================================
// External binning circuit
// ==========================================
module lbo_bin_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [3:0] port_out,
   input wire logic bs_en,
   input wire logic pol4,
   output logic cap_valid,
   output logic [2:0] cap_bits,
   output logic [15:0] cap_width
);
   logic act;
   logic was_act;
   logic in_pulse;

   // The strobe is active when line 4 sits at its polarity level.
   assign act = (port_out[3] == pol4);

   // Lines 1 to 3 are taken at the leading edge, the only moment they are promised valid.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         was_act <= 1'b1;
         in_pulse <= 1'b0;
         cap_valid <= 1'b0;
         cap_bits <= 3'b000;
         cap_width <= 16'h0000;
      end else begin
         was_act <= act;
         cap_valid <= 1'b0;
         if (bs_en && act && !was_act) begin
            in_pulse <= 1'b1;
            cap_bits <= port_out[2:0];
            cap_width <= 16'h0001;
         end else if (in_pulse && act) begin
            cap_width <= cap_width + 16'h0001;
         end else if (in_pulse) begin
            in_pulse <= 1'b0;
            cap_valid <= 1'b1;
         end
      end
   end
endmodule

/* File: verif/limit_binning_output_bench.sv */
`timescale 1ns/1ps
// ==========================================
// Bench top
// ==========================================
module limit_binning_output_bench;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, composite_fail;
   logic [31:0] haddr, hwdata, hrdata, rnd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [3:0] port_out, pol, pat;
   lbo_pkg::lbo_reading_t reading;
   logic bs_en, pol4, cap_valid;
   logic [2:0] cap_bits;
   logic [15:0] cap_width;
   logic [31:0] exp_q[$];
   int failures, checks, caps, seed;

   lbo_limit_bin lbo_limit_bin_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .reading(reading),
      .port_out(port_out), .composite_fail(composite_fail));
   lbo_bin_model lbo_bin_model_i (.hclk(hclk), .hresetn(hresetn), .port_out(port_out),
      .bs_en(bs_en), .pol4(pol4), .cap_valid(cap_valid), .cap_bits(cap_bits),
      .cap_width(cap_width));

   // Free-running 100 MHz clock.
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic results();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Bounded wait for hready; a bus that never answers ends the run.
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 16);
      if (hreadyout !== 1'b1) begin
         failures++;
         results();
      end
   endtask

   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      htrans <= 2'b10;
      hwrite <= wr;
      haddr <= {24'h00_0000, a};
      wait_ready();
      htrans <= 2'b00;
      hwdata <= d;
      wait_ready();
      q = hrdata;
      check("hresp", {31'h0000_0000, hresp}, 32'h0000_0000);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   // The expectation is queued first; the task pops and compares it when the data arrive.
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      exp_q.push_back(e);
      bus(1'b0, a, 32'h0000_0000, q);
      check("read", q, exp_q.pop_front());
   endtask

   // One conversion result, then time for the port to update.
   task automatic sample(input logic [31:0] v);
      reading <= '{valid: 1'b1, value: v};
      @(posedge hclk);
      reading.valid <= 1'b0;
      repeat (2) @(posedge hclk);
   endtask

   task automatic wait_cap(input int c0);
      int n;
      n = 0;
      while (caps == c0 && n < 1500) begin
         @(posedge hclk);
         n++;
      end
      if (caps == c0) begin
         failures++;
         results();
      end
   endtask

   // Each strobe seen by the binning model settles the oldest queued note.
   always @(posedge hclk) begin
      if (cap_valid === 1'b1) begin
         caps++;
         check("strobe", {28'h000_0000, cap_width > 16'd1000, cap_bits}, exp_q.pop_front());
      end
   end

   // ==========================================
   // Main sequence
   // ==========================================
   initial begin
      seed = 32'h64cc82cf;
      hresetn = 1'b0;
      hsel = 1'b1;
      haddr = '0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = '0;
      reading = '0;
      bs_en = 1'b0;
      pol4 = 1'b1;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      check("port_rst", {28'h0, port_out}, 32'h0);
      rd(lbo_pkg::OFF_CTRL, 32'h0000_00F0);
      rd(lbo_pkg::OFF_PASS, 32'h0000_0000);
      rd(lbo_pkg::OFF_STAT, 32'h0000_0000);
      rd(8'h3C, 32'h0000_0000);
      // Every pass pattern under a random polarity, no test enabled.
      for (int i = 0; i < 16; i++) begin
         rnd = $random(seed);
         pol = rnd[3:0];
         wr(lbo_pkg::OFF_CTRL, {24'h0, pol, 4'h0});
         wr(lbo_pkg::OFF_PASS, i);
         rd(lbo_pkg::OFF_PASS, i);
         sample(rnd);
         check("pass_port", {28'h0, port_out}, {28'h0, i[3:0] ~^ pol});
      end
      // Strobe on, with both directions of line 4.
      for (int k = 0; k < 2; k++) begin
         rnd = $random(seed);
         pol = {k[0], rnd[2:0]};
         pat = {1'b1, rnd[6:4]};
         bs_en <= 1'b0;
         wr(lbo_pkg::OFF_CTRL, {24'h0, pol, 4'h4});
         pol4 <= pol[3];
         bs_en <= 1'b1;
         wr(lbo_pkg::OFF_PASS, {28'h000_0000, pat});
         rd(lbo_pkg::OFF_CTRL, {24'h0, pol, 4'h4});
         exp_q.push_back({28'h000_0000, 1'b1, pat[2:0] ~^ pol[2:0]});
         sample(32'h0000_0000);
         check("line4_idle", {31'h0, port_out[3]}, {31'h0, ~pol[3]});
         check("lines123", {29'h0, port_out[2:0]}, {29'h0, pat[2:0] ~^ pol[2:0]});
         wait_cap(caps);
      end
      // Limit tests, first failure wins, sticky flags.
      bs_en <= 1'b0;
      wr(lbo_pkg::OFF_CTRL, 32'h0000_00F3);
      wr(lbo_pkg::OFF_FPAT, 32'h0000_4321);
      wr(lbo_pkg::OFF_L1LO, -32'sd10);
      wr(lbo_pkg::OFF_L1HI, 32'sd10);
      wr(lbo_pkg::OFF_L2LO, -32'sd5);
      wr(lbo_pkg::OFF_L2HI, 32'sd5);
      wr(lbo_pkg::OFF_PASS, 32'h0000_0005);
      sample(32'd20);
      check("first_fail", {28'h0, port_out}, 32'h0000_0002);
      check("comp_fail", {31'h0, composite_fail}, 32'h0000_0001);
      rd(lbo_pkg::OFF_STAT, 32'h0000_0027);
      rd(lbo_pkg::OFF_STAT, 32'h0000_0027);
      wr(lbo_pkg::OFF_L1HI, 32'sd100);
      repeat (3) @(posedge hclk);
      check("no_retest", {28'h0, port_out}, 32'h0000_0002);
      wr(lbo_pkg::OFF_CMD, 32'h0000_0001);
      repeat (3) @(posedge hclk);
      check("reeval", {28'h0, port_out}, 32'h0000_0004);
      wr(lbo_pkg::OFF_CMD, 32'h0000_0006);
      rd(lbo_pkg::OFF_STAT, 32'h0000_0040);
      sample(-32'sd7);
      check("low2_fail", {28'h0, port_out}, 32'h0000_0003);
      rd(lbo_pkg::OFF_LAST, -32'sd7);
      sample(32'd0);
      check("all_pass", {28'h0, port_out}, 32'h0000_0005);
      check("sticky", {31'h0, composite_fail}, 32'h0000_0001);
      // A reading below the first low limit also fails the second low limit; the first wins.
      sample(-32'sd20);
      check("low1_first", {28'h0, port_out}, 32'h0000_0001);
      // Disabling the second limit drops its flag, the composite keeps the first.
      wr(lbo_pkg::OFF_CTRL, 32'h0000_00F1);
      rd(lbo_pkg::OFF_STAT, 32'h0000_0015);
      results();
   end
endmodule
